// *** port3_map.svh ***
// register offsets, reset values and field codes for the port 3 configuration block
`ifndef PORT3_MAP_SVH
`define PORT3_MAP_SVH
`define EDGE_CFG_HIGH_ADDR 8'he8
`define PULLUP_EN_ADDR 8'hec
`define OPEN_DRAIN_ADDR 8'hed
`define PENDING_ADDR 8'he7
`define REG_RESET 8'h00
`define PORT_PIN_MASK 8'h7f
`define EDGE_OFF 2'h0
`define EDGE_FALL 2'h1
`define EDGE_RISE 2'h2
`define EDGE_BOTH 2'h3
`define PIN_MODE_INPUT 2'h0
`define PIN_MODE_OUTPUT 2'h1
`define LINE4_PIN 0
`define LINE5_PIN 1
`define LINE6_PIN 2
`define LINE7_PIN 3
`define PIN_MODE_BITS 2
`define EDGE_FIELD_BITS 2
`define EXT_LINE_COUNT 4
`define PAD_REG_BITS 7
`define PEND_FIELD_LSB 4
`define PEND_LOW_READ 4'h0
`endif

// *** port3_pkg.sv ***
// types shared by the port 3 configuration block
package port3_pkg;
  typedef logic [1:0] edge_cfg_t;
  typedef logic [7:0] reg_byte_t;
endpackage

// *** edge_detect.sv ***
// one external interrupt line: edge qualifier and sticky pending bit
`include "port3_map.svh"
module edge_detect (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // configuration
  input wire port3_pkg::edge_cfg_t edge_cfg,
  // pin level, synchronous to clock
  input wire logic pin,
  // software clear of the pending bit
  input wire logic clear,
  // sticky pending flag
  output logic pending
);
  import port3_pkg::*;

  logic pin_prev;
  logic hit;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin;
    end
  end

  always_comb begin
    case (edge_cfg)
      `EDGE_FALL: hit = pin_prev & ~pin;
      `EDGE_RISE: hit = ~pin_prev & pin;
      `EDGE_BOTH: hit = pin_prev ^ pin;
      default: hit = 1'b0;
    endcase
  end

  // set wins over clear so an edge in the clearing cycle is kept
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pending <= 1'b0;
    end else if (hit) begin
      pending <= 1'b1;
    end else if (clear) begin
      pending <= 1'b0;
    end
  end
endmodule

// *** port3_config.sv ***
// port 3 pull-up, output type and high-byte external interrupt configuration
// Function
// - bits 0-6 of pull-up register enable each pin's pull-up when one.
// - pull-up forced off for push-pull outputs and alternative functions.
// - bits 0-6 select push-pull (0) or open-drain (1) per pin.
// - line 7 field 7:6 codes off, falling, rising, both edges.
// - lines 5 and 4 use fields 3:2 and 1:0, same encoding.
// - qualifying edge sets pending bit, request goes low; software writes 0 to clear.
`include "port3_map.svh"
module port3_config #(
  // number of port pins served
  parameter int PIN_COUNT = 7
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // register file access, direct register addressing only
  input wire port3_pkg::reg_byte_t reg_addr,
  input wire port3_pkg::reg_byte_t reg_wdata,
  input wire logic reg_write,
  output port3_pkg::reg_byte_t reg_rdata,
  // pin mode from the port 3 control registers, two bits per pin
  input wire logic [`PIN_MODE_BITS*PIN_COUNT-1:0] pin_mode,
  // pin levels, synchronous to clock
  input wire logic [PIN_COUNT-1:0] pin_in,
  // pad controls
  output logic [PIN_COUNT-1:0] pullup_on,
  output logic [PIN_COUNT-1:0] open_drain,
  // interrupt lines 7..4 pending and request
  output logic [`EXT_LINE_COUNT-1:0] line_pending,
  output logic irq_n
);
  import port3_pkg::*;

  // ************
  // parameter checks
  // ************
  // both interrupt bytes hold exactly four lines, so the line count is fixed
  localparam int LINE_COUNT = `EXT_LINE_COUNT;
  localparam reg_byte_t PIN_MASK = reg_byte_t'({PIN_COUNT{1'b1}});

  // bit 7 of the pad registers is reserved
  if (PIN_COUNT > `PAD_REG_BITS) begin : g_pins_above_reg
    $error("port3_config: PIN_COUNT exceeds the pad register width");
  end

  // lines 7..4 sit on the low pins
  if (PIN_COUNT <= `LINE7_PIN) begin : g_pins_below_lines
    $error("port3_config: PIN_COUNT leaves interrupt lines without pins");
  end

  if (`EDGE_FIELD_BITS * LINE_COUNT != $bits(reg_byte_t)) begin : g_fields_fill_byte
    $error("port3_config: edge fields do not fill the configuration byte");
  end

  // ************
  // helpers
  // ************
  // one address compare shared by every register and by the clear strobe
  function automatic logic write_hit(input logic wr, input reg_byte_t addr,
                                     input reg_byte_t target);
    return wr && (addr == target);
  endfunction

  // mode field of one pin
  function automatic logic [`PIN_MODE_BITS-1:0] mode_of(
      input logic [`PIN_MODE_BITS*PIN_COUNT-1:0] modes, input int pin);
    return modes[`PIN_MODE_BITS*pin +: `PIN_MODE_BITS];
  endfunction

  // inputs and open-drain outputs keep the pull-up, push-pull and alternatives do not
  function automatic logic pullup_allowed(input logic [`PIN_MODE_BITS-1:0] mode,
                                          input logic drain_sel);
    case (mode)
      `PIN_MODE_INPUT: return 1'b1;
      `PIN_MODE_OUTPUT: return drain_sel;
      default: return 1'b0;
    endcase
  endfunction

  // edge configuration field of one line
  function automatic edge_cfg_t edge_field(input reg_byte_t cfg, input int idx);
    return cfg[`EDGE_FIELD_BITS*idx +: `EDGE_FIELD_BITS];
  endfunction

  // pin that carries each external interrupt line
  function automatic int line_pin_index(input int idx);
    case (idx)
      0: return `LINE4_PIN;
      1: return `LINE5_PIN;
      2: return `LINE6_PIN;
      default: return `LINE7_PIN;
    endcase
  endfunction

  reg_byte_t ext_int_edge_config_high;
  reg_byte_t port3_pullup_enable;
  reg_byte_t port3_open_drain_select;
  reg_byte_t pending_view;
  logic wr_edge_cfg;
  logic wr_pullup;
  logic wr_open_drain;
  logic wr_pending;
  logic [LINE_COUNT-1:0] pend_clear;
  logic [LINE_COUNT-1:0] line_pin;
  logic [PIN_COUNT-1:0] next_pullup_on;

  // ************
  // write decode
  // ************
  // only direct register writes reach these, so a plain address match suffices
  assign wr_edge_cfg = write_hit(reg_write, reg_addr, `EDGE_CFG_HIGH_ADDR);
  assign wr_pullup = write_hit(reg_write, reg_addr, `PULLUP_EN_ADDR);
  assign wr_open_drain = write_hit(reg_write, reg_addr, `OPEN_DRAIN_ADDR);
  assign wr_pending = write_hit(reg_write, reg_addr, `PENDING_ADDR);

  // ************
  // registers
  // ************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ext_int_edge_config_high <= `REG_RESET;
    end else if (wr_edge_cfg) begin
      ext_int_edge_config_high <= reg_wdata;
    end
  end

  // reserved bit 7 and unserved pins never store a one
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      port3_pullup_enable <= `REG_RESET;
    end else if (wr_pullup) begin
      port3_pullup_enable <= reg_wdata & PIN_MASK;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      port3_open_drain_select <= `REG_RESET;
    end else if (wr_open_drain) begin
      port3_open_drain_select <= reg_wdata & PIN_MASK;
    end
  end

  // ************
  // pending clear and read back
  // ************
  // writing 0 to a pending bit clears it, writing 1 leaves it
  always_comb begin
    pend_clear = '0;
    if (wr_pending) begin
      pend_clear = ~reg_wdata[`PEND_FIELD_LSB +: LINE_COUNT];
    end
  end

  // lines 7..4 sit in the upper half, the lower half belongs to other lines
  assign pending_view = {line_pending, `PEND_LOW_READ};

  // unmapped addresses read 0
  always_comb begin
    case (reg_addr)
      `EDGE_CFG_HIGH_ADDR: reg_rdata = ext_int_edge_config_high;
      `PULLUP_EN_ADDR: reg_rdata = port3_pullup_enable;
      `OPEN_DRAIN_ADDR: reg_rdata = port3_open_drain_select;
      `PENDING_ADDR: reg_rdata = pending_view;
      default: reg_rdata = `REG_RESET;
    endcase
  end

  // ************
  // pad controls
  // ************
  // an open-drain output still needs the pull-up for its high level
  always_comb begin
    next_pullup_on = '0;
    for (int i = 0; i < PIN_COUNT; i++) begin
      next_pullup_on[i] = port3_pullup_enable[i] &&
                          pullup_allowed(mode_of(pin_mode, i),
                                         port3_open_drain_select[i]);
    end
  end

  // registered, so the pad sees one settled value per cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pullup_on <= '0;
    end else begin
      pullup_on <= next_pullup_on;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      open_drain <= '0;
    end else begin
      open_drain <= port3_open_drain_select[PIN_COUNT-1:0];
    end
  end

  // ************
  // external interrupts
  // ************
  always_comb begin
    line_pin = '0;
    for (int k = 0; k < LINE_COUNT; k++) begin
      line_pin[k] = pin_in[line_pin_index(k)];
    end
  end

  for (genvar k = 0; k < LINE_COUNT; k++) begin : g_line
    edge_detect edge_detect_inst (
      .clock(clock),
      .nrst(nrst),
      .edge_cfg(edge_field(ext_int_edge_config_high, k)),
      .pin(line_pin[k]),
      .clear(pend_clear[k]),
      .pending(line_pending[k])
    );
  end

  // ************
  // interrupt request
  // ************
  // request is active low while any line is pending
  assign irq_n = ~|line_pending;
endmodule

// *** port3_config_sva.sv ***
// assertions on the port 3 configuration block
module port3_config_sva (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // register file access
  input wire logic reg_write,
  input wire port3_pkg::reg_byte_t reg_addr,
  input wire port3_pkg::reg_byte_t reg_wdata,
  input wire port3_pkg::reg_byte_t reg_rdata,
  // pins and pad controls
  input wire logic [13:0] pin_mode,
  input wire logic [6:0] pin_in,
  input wire logic [6:0] pullup_on,
  input wire logic [6:0] open_drain,
  // interrupt lines
  input wire logic [3:0] line_pending,
  input wire logic irq_n
);
  import port3_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [6:0] inm, outm, pp;
  logic [7:0] cfg;
  logic [3:0] hit;
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      inm[i] = pin_mode[2*i+:2] == 2'h0;
      outm[i] = pin_mode[2*i+:2] == 2'h1;
    end
  end
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      hit[k] = cfg[2*k+1] & pin_in[k] & ~pp[k] | cfg[2*k] & ~pin_in[k] & pp[k];
    end
  end
  // history starts low, as the block's own does
  always_ff @(posedge clock or negedge nrst)
    if (!nrst) pp <= 7'h0;
    else pp <= pin_in;
  always_ff @(posedge clock or negedge nrst)
    if (!nrst) cfg <= 8'h0;
    else if (reg_write && reg_addr == 8'he8) cfg <= reg_wdata;
  // open-drain outputs keep the pull-up, so the gate takes the drain select as well
  a_pullup_gate: assert property (
    reg_addr == 8'hec |=>
    {1'b0, pullup_on} == ($past(reg_rdata) & {1'b0, $past(inm) | ($past(outm) & open_drain)}))
    else $error("pullup wrong");
  a_od_copy: assert property (
    (reg_addr == 8'hed && !reg_write) [*2] |-> open_drain == reg_rdata[6:0])
    else $error("open drain wrong");
  a_cfg_readback: assert property (
    reg_write && reg_addr == 8'he8 ##1 reg_addr == 8'he8 |-> reg_rdata == $past(reg_wdata))
    else $error("edge config wrong");
  a_edge_sets: assert property (
    |hit |=> (line_pending & $past(hit)) == $past(hit)) else $error("edge missed");
  a_no_spurious: assert property (
    (line_pending & ~$past(line_pending) & ~$past(hit)) == 4'h0) else $error("spurious");
  a_pend_clear: assert property (
    reg_write && reg_addr == 8'he7 && !reg_wdata[7] && !hit[3] |=> !line_pending[3])
    else $error("not cleared");
  a_irq_level: assert property (irq_n == ~|line_pending) else $error("irq wrong");
  c_edge: cover property (|hit);
  c_clear: cover property (reg_write && reg_addr == 8'he7);
  c_gate: cover property (~&inm && |pullup_on);
  c_od_pullup: cover property (|(outm & open_drain & pullup_on));
endmodule
bind port3_config port3_config_sva port3_config_sva_inst (
  .clock(clock),
  .nrst(nrst),
  .reg_write(reg_write),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .pin_mode(pin_mode),
  .pin_in(pin_in),
  .pullup_on(pullup_on),
  .open_drain(open_drain),
  .line_pending(line_pending),
  .irq_n(irq_n)
);

// *** tb_top.sv ***
// self-checking bench for the port 3 configuration block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import port3_pkg::*;
  logic clock = 1'b0, nrst = 1'b0, reg_write = 1'b0, irq_n;
  reg_byte_t reg_addr = 8'h0, reg_wdata = 8'h0, reg_rdata;
  logic [13:0] pin_mode = 14'h0;
  logic [6:0] pin_in = 7'h0, pullup_on, open_drain;
  logic [3:0] line_pending;
  int num_errors = 0, n_tests = 0, cycle_count = 0;
  port3_config port3_config_inst (
    .clock(clock),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_rdata(reg_rdata),
    .pin_mode(pin_mode),
    .pin_in(pin_in),
    .pullup_on(pullup_on),
    .open_drain(open_drain),
    .line_pending(line_pending),
    .irq_n(irq_n)
  );
  initial forever #4 clock = ~clock;
  // the whole run needs about 60 cycles
  initial begin
    while (cycle_count < 2000) begin
      @(posedge clock);
      cycle_count++;
    end
    num_errors++;
    report_and_stop();
  end
  task chk(string n, reg_byte_t s, e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // plain address on the register file, the only access path
  task wr(reg_byte_t a, d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
  endtask
  task rd(reg_byte_t a, e);
    @(negedge clock);
    reg_addr = a;
    #1 chk("rdata", reg_rdata, e);
  endtask
  task report_and_stop();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    rd(8'hec, 8'h0);
    wr(8'hec, 8'hff);
    rd(8'hec, 8'h7f);
    chk("pullup", pullup_on, 8'h7f);
    pin_mode = 14'h0009;
    rd(8'hec, 8'h7f);
    chk("pullup", pullup_on, 8'h7c);
    repeat (2) @(negedge clock);
    wr(8'hed, 8'hff);
    rd(8'hed, 8'h7f);
    chk("odrain", open_drain, 8'h7f);
    rd(8'hec, 8'h7f);
    chk("pullup", pullup_on, 8'h7d);
    $display("test pads done");
    for (int c = 0; c < 4; c++) begin
      wr(8'he8, 8'(c << 6));
      pin_in[3] = 1'b1;
      rd(8'he8, 8'(c << 6));
      chk("rise", line_pending[3], 8'(c >> 1));
      wr(8'he7, 8'h0);
      pin_in[3] = 1'b0;
      rd(8'he7, 8'(c << 7));
      chk("irq", irq_n, 8'(~c & 1));
      wr(8'he7, 8'h0);
    end
    wr(8'he8, 8'h2a);
    pin_in[2:0] = 3'h7;
    rd(8'he7, 8'h70);
    chk("irq", irq_n, 8'h0);
    wr(8'he7, 8'hdf);
    rd(8'he7, 8'h50);
    rd(8'h0, 8'h0);
    $display("test edges done");
    report_and_stop();
  end
endmodule
